// [hw/qpfep_pkg.sv]
// Constants and types shared by the quad phase fetch/execute sequencer.
package qpfep_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int PROG_ADDR_W = 16;
  localparam int PROG_WORD_W = 16;
  localparam int DATA_ADDR_W = 8;
  localparam int DATA_WORD_W = 8;
  localparam int PHASE_COUNT = 4;

  // ----------------------------------------------------------------------
  // Reset values and program counter step
  // ----------------------------------------------------------------------
  localparam logic [PROG_ADDR_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [PROG_ADDR_W-1:0] PC_STEP = 16'h0001;
  localparam logic [PROG_WORD_W-1:0] HOLD_RESET = 16'h0000;
  localparam logic [DATA_ADDR_W-1:0] DATA_ADDR_RESET = 8'h00;
  localparam logic [DATA_WORD_W-1:0] DATA_WORD_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Phase encoding and one-hot phase outputs
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ONE = 2'h0,
    PH_TWO = 2'h1,
    PH_THREE = 2'h3,
    PH_FOUR = 2'h2
  } qpfep_phase_t;

  localparam int PH_BIT_ONE = 0;
  localparam int PH_BIT_TWO = 1;
  localparam int PH_BIT_THREE = 2;
  localparam int PH_BIT_FOUR = 3;
  localparam logic [PHASE_COUNT-1:0] PHV_ONE = 4'h1;
  localparam logic [PHASE_COUNT-1:0] PHV_TWO = 4'h2;
  localparam logic [PHASE_COUNT-1:0] PHV_THREE = 4'h4;
  localparam logic [PHASE_COUNT-1:0] PHV_FOUR = 4'h8;

  // ----------------------------------------------------------------------
  // Data memory request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [DATA_ADDR_W-1:0] addr;
    logic [DATA_WORD_W-1:0] wrData;
  } qpfep_dmem_req_t;

  localparam qpfep_dmem_req_t DMEM_IDLE = '{
    rdEn: 1'b0,
    wrEn: 1'b0,
    addr: DATA_ADDR_RESET,
    wrData: DATA_WORD_RESET
  };

endpackage

// [hw/qpfep_core.sv]
// Four phase clocking and two stage fetch/execute sequencing of the core.
//
// Function
// RL1 - Divide the clock by four into four non-overlapping repeating phases.
// RL2 - An instruction cycle is phase one, two, three, four in order.
// RL3 - Program counter increments once per cycle in phase one, starting fetch.
// RL4 - Program word is read during fetch and captured by end of phase four.
// RL5 - Captured word loads the instruction hold register at next phase one.
// RL6 - Held instruction is decoded and executed in phases two to four.
// RL7 - Fetch overlaps execution, giving one instruction per cycle.
// RL8 - Operand read in phase two, destination written in phase four.
// RL9 - Instructions that change the program counter take two cycles.
// RL10 - A taken branch discards the prefetched word and fetches the target.
// RL11 - After reset the hold register is empty; first cycle only fetches.
`timescale 1ns/1ps
`default_nettype none

module qpfep_core
  import qpfep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [PROG_WORD_W-1:0] progWord,
  input wire logic branchReq,
  input wire logic [PROG_ADDR_W-1:0] branchTarget,
  input wire logic [DATA_ADDR_W-1:0] operandAddr,
  input wire logic destWrite,
  input wire logic [DATA_WORD_W-1:0] destData,
  input wire logic [DATA_WORD_W-1:0] dataRdWord,
  output logic [PHASE_COUNT-1:0] phaseVec,
  output logic [PROG_ADDR_W-1:0] progAddr,
  output logic [PROG_WORD_W-1:0] instrHold,
  output logic instrValid,
  output logic [DATA_WORD_W-1:0] operandWord,
  output qpfep_dmem_req_t dmemReq
);

  // ----------------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------------
  qpfep_phase_t phase;
  qpfep_phase_t next_phase;
  logic [PHASE_COUNT-1:0] next_phaseVec;

  always_comb begin
    unique case (phase)
      PH_ONE: next_phase = PH_TWO; // RL2
      PH_TWO: next_phase = PH_THREE; // RL2
      PH_THREE: next_phase = PH_FOUR; // RL2
      PH_FOUR: next_phase = PH_ONE; // RL1
    endcase
  end

  assign next_phaseVec = (next_phase == PH_ONE) ? PHV_ONE :
                         (next_phase == PH_TWO) ? PHV_TWO :
                         (next_phase == PH_THREE) ? PHV_THREE : PHV_FOUR;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase <= PH_ONE;
      phaseVec <= PHV_ONE;
    end else if (clkEn) begin
      phase <= next_phase; // RL1
      phaseVec <= next_phaseVec; // RL1
    end
  end

  // ----------------------------------------------------------------------
  // Phase boundaries
  // ----------------------------------------------------------------------
  wire endOne = clkEn && (phase == PH_ONE);
  wire endTwo = clkEn && (phase == PH_TWO);
  wire endThree = clkEn && (phase == PH_THREE);
  wire endFour = clkEn && (phase == PH_FOUR);

  // The branch is judged at the close of the execute cycle, so the
  // executor has phases two to four to settle its decision.
  wire takeBranch = endFour && instrValid && branchReq; // RL9

  // ----------------------------------------------------------------------
  // Fetch stage
  // ----------------------------------------------------------------------
  logic [PROG_ADDR_W-1:0] pc;
  logic [PROG_WORD_W-1:0] fetchWord;
  wire [PROG_ADDR_W-1:0] fetchTarget = takeBranch ? branchTarget : pc;
  wire [PROG_ADDR_W-1:0] next_pc = PROG_ADDR_W'(fetchTarget + PC_STEP);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pc <= PROG_ADDR_W'(RESET_VECTOR + PC_STEP);
      progAddr <= RESET_VECTOR;
    end else if (endFour) begin
      progAddr <= fetchTarget; // RL10
      pc <= next_pc; // RL3
    end
  end

  // The word is taken at the end of phase three, so it is stable inside
  // phase four and memory has three phases of access time.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fetchWord <= HOLD_RESET;
    end else if (endThree) begin
      fetchWord <= progWord; // RL4
    end
  end

  // ----------------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      instrHold <= HOLD_RESET;
      instrValid <= 1'b0; // RL11
    end else if (endFour) begin // RL7
      instrHold <= fetchWord; // RL5
      instrValid <= !takeBranch; // RL10
    end
  end

  wire next_rdEn = endOne && instrValid;
  wire next_wrEn = endThree && instrValid && destWrite;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dmemReq <= DMEM_IDLE;
      operandWord <= DATA_WORD_RESET;
    end else if (clkEn) begin
      dmemReq.rdEn <= next_rdEn; // RL8
      dmemReq.wrEn <= next_wrEn; // RL8
      if (endOne) begin
        dmemReq.addr <= operandAddr; // RL6
      end
      if (endThree) begin
        dmemReq.wrData <= destData; // RL6
      end
      if (endTwo && dmemReq.rdEn) begin
        operandWord <= dataRdWord; // RL8
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_fourEnabled;
    clkEn [*4];
  endsequence

  sequence s_branchTaken;
    clkEn && phaseVec[PH_BIT_FOUR] && instrValid && branchReq;
  endsequence

  property p_phasePeriod;
    @(posedge sys_clk) disable iff (!reset_n)
      (phaseVec[PH_BIT_ONE] ##0 s_fourEnabled) |=> phaseVec[PH_BIT_ONE];
  endproperty

  a_phase_onehot: assert property (@(posedge sys_clk) // RL1
    disable iff (!reset_n) $onehot(phaseVec))
    else $error("phase outputs not one-hot");

  a_phase_period: assert property (p_phasePeriod) // RL1
    else $error("phase one does not repeat every four phases");

  a_phase_order: assert property (@(posedge sys_clk) // RL2
    disable iff (!reset_n) (clkEn && phaseVec[PH_BIT_TWO]) |=>
      phaseVec[PH_BIT_THREE])
    else $error("phase three does not follow phase two");

  a_pc_step: assert property (@(posedge sys_clk) // RL3
    disable iff (!reset_n) (endFour && !takeBranch) |=>
      (progAddr == $past(pc)) && (pc == PROG_ADDR_W'($past(pc) + PC_STEP)))
    else $error("program counter did not step at phase one");

  a_pc_hold: assert property (@(posedge sys_clk) // RL3
    disable iff (!reset_n) !endFour |=> $stable(pc) && $stable(progAddr))
    else $error("program counter moved outside phase one");

  a_fetch_hold: assert property (@(posedge sys_clk) // RL5
    disable iff (!reset_n) (endThree ##1 endFour) |=>
      instrHold == $past(progWord, 2))
    else $error("held instruction is not the fetched word");

  a_operand_read: assert property (@(posedge sys_clk) // RL8
    disable iff (!reset_n) dmemReq.rdEn |->
      phaseVec[PH_BIT_TWO] && instrValid)
    else $error("operand read outside phase two");

  a_dest_write: assert property (@(posedge sys_clk) // RL8
    disable iff (!reset_n) dmemReq.wrEn |->
      phaseVec[PH_BIT_FOUR] && instrValid)
    else $error("destination write outside phase four");

  a_branch_flush: assert property (@(posedge sys_clk) // RL10
    disable iff (!reset_n) s_branchTaken |=>
      !instrValid && (progAddr == $past(branchTarget)))
    else $error("taken branch did not flush and redirect");

  a_branch_twocyc: assert property (@(posedge sys_clk) // RL9
    disable iff (!reset_n) (s_branchTaken ##1 s_fourEnabled) |=>
      instrValid)
    else $error("branch target not executing in second cycle");

  a_overlap_run: assert property (@(posedge sys_clk) // RL7
    disable iff (!reset_n) (endFour && instrValid && !branchReq) |=>
      instrValid)
    else $error("pipeline bubble without a branch");

  a_reset_empty: assert property (@(posedge sys_clk) // RL11
    $rose(reset_n) |-> !instrValid && phaseVec[PH_BIT_ONE])
    else $error("hold register not empty after reset");

  a_enable_freeze: assert property (@(posedge sys_clk) // RL1
    disable iff (!reset_n) !clkEn |=> $stable(phaseVec) &&
      $stable(progAddr) && $stable(instrHold) && $stable(instrValid) &&
      $stable(dmemReq) && $stable(operandWord))
    else $error("state moved while the clock enable was low");

  a_operand_take: assert property (@(posedge sys_clk) // RL8
    disable iff (!reset_n) (endTwo && dmemReq.rdEn) |=>
      operandWord == $past(dataRdWord))
    else $error("operand word is not the data read in phase two");

endmodule

`default_nettype wire

// [hw/_unused_guard.sv]
// Intentionally empty design unit holder.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [bench/qpfep_mem_model.sv]
// Program and data memory model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module qpfep_mem_model
  import qpfep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [PROG_ADDR_W-1:0] progAddr,
  output logic [PROG_WORD_W-1:0] progWord,
  input wire qpfep_dmem_req_t dmemReq,
  output logic [DATA_WORD_W-1:0] dataRdWord
);
  logic [DATA_WORD_W-1:0] mem [256];
  logic [DATA_WORD_W-1:0] lastOut = 8'h00;
  assign progWord = {progAddr[7:0] ^ 8'h3c, progAddr[15:8]};
  // An idle read line never holds its old value, so a late sample shows.
  assign dataRdWord = dmemReq.rdEn ? mem[dmemReq.addr] : ~lastOut;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  always @(posedge sys_clk) begin
    lastOut <= dataRdWord;
    if (dmemReq.wrEn) begin
      mem[dmemReq.addr] <= dmemReq.wrData;
    end
  end
endmodule
`default_nettype wire

// [bench/qpfep_core_tb_top.sv]
// Self-checking bench for the quad phase fetch/execute sequencer.
`timescale 1ns/1ps
`default_nettype none
module qpfep_core_tb_top
  import qpfep_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic branchReq = 1'b0;
  logic destWrite = 1'b0;
  logic [PROG_ADDR_W-1:0] branchTarget = 16'h0000;
  logic [DATA_ADDR_W-1:0] operandAddr = 8'h00;
  logic [DATA_WORD_W-1:0] destData = 8'h00;
  logic [PROG_WORD_W-1:0] progWord, instrHold, eHold;
  logic [PROG_ADDR_W-1:0] progAddr, ePc;
  logic [DATA_WORD_W-1:0] dataRdWord, operandWord;
  logic [DATA_WORD_W-1:0] shadow [256];
  logic [PHASE_COUNT-1:0] phaseVec;
  logic instrValid, eValid;
  qpfep_dmem_req_t dmemReq;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  qpfep_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
    .progWord(progWord), .branchReq(branchReq),
    .branchTarget(branchTarget), .operandAddr(operandAddr),
    .destWrite(destWrite), .destData(destData), .dataRdWord(dataRdWord),
    .phaseVec(phaseVec), .progAddr(progAddr), .instrHold(instrHold),
    .instrValid(instrValid), .operandWord(operandWord), .dmemReq(dmemReq));
  qpfep_mem_model mem (.sys_clk(sys_clk), .progAddr(progAddr),
    .progWord(progWord), .dmemReq(dmemReq), .dataRdWord(dataRdWord));
  function automatic logic [15:0] wordAt(logic [15:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8]};
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The run needs about 350 cycles, so this ceiling only catches a hang.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    clkEn <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("frozen phase", 16'(phaseVec), 16'(PHV_ONE));
    check("reset valid", 16'(instrValid), 16'h0000);
    check("reset req", 16'(dmemReq.rdEn | dmemReq.wrEn), 16'h0000);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    ePc = RESET_VECTOR;
    eValid = 1'b0;
  endtask
  task automatic instr_cycle(int i);
    logic [7:0] oa, dd;
    logic dw, br;
    logic [15:0] bt;
    logic stall;
    oa = 8'($urandom);
    stall = ($urandom % 4 == 0);
    dd = 8'($urandom);
    dw = 1'($urandom);
    br = ($urandom % 3 == 0) || (i == 3) || (i == 4);
    bt = (i == 3) ? 16'hffff : 16'($urandom);
    operandAddr <= oa;
    @(negedge sys_clk);
    check("phase one", 16'(phaseVec), 16'(PHV_ONE));
    check("fetch addr", progAddr, ePc);
    check("valid", 16'(instrValid), 16'(eValid));
    if (eValid) check("hold", instrHold, eHold);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("phase two", 16'(phaseVec), 16'(PHV_TWO));
    check("read strobe", 16'(dmemReq.rdEn), 16'(eValid));
    if (eValid) check("read addr", 16'(dmemReq.addr), 16'(oa));
    @(posedge sys_clk);
    destWrite <= dw;
    destData <= dd;
    clkEn <= !stall;
    @(negedge sys_clk);
    check("phase three", 16'(phaseVec), 16'(PHV_THREE));
    check("read end", 16'(dmemReq.rdEn), 16'h0000);
    if (eValid) check("operand", 16'(operandWord), 16'(shadow[oa]));
    if (stall) begin
      @(posedge sys_clk);
      clkEn <= 1'b1;
      @(negedge sys_clk);
      check("stall phase", 16'(phaseVec), 16'(PHV_THREE));
      check("stall write", 16'(dmemReq.wrEn), 16'h0000);
      if (eValid) begin
        check("held operand", 16'(operandWord), 16'(shadow[oa]));
      end
    end
    @(posedge sys_clk);
    branchReq <= br;
    branchTarget <= bt;
    @(negedge sys_clk);
    check("phase four", 16'(phaseVec), 16'(PHV_FOUR));
    check("write strobe", 16'(dmemReq.wrEn), 16'(dw & eValid));
    if (dw & eValid) begin
      check("write", {dmemReq.addr, dmemReq.wrData}, {oa, dd});
      shadow[oa] = dd;
    end
    @(posedge sys_clk);
    eHold = wordAt(ePc);
    ePc = (br & eValid) ? bt : ePc + PC_STEP;
    eValid = !(br & eValid);
  endtask
  initial begin
    void'($urandom(32'hb511_40b4));
    for (int k = 0; k < 256; k++) begin
      shadow[k] = 8'(k) ^ 8'h5a;
    end
    for (int r = 0; r < 2; r++) begin
      do_reset();
      for (int i = 0; i < 40; i++) begin
        instr_cycle(i);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
